// ==== lcci_consts.svh ====
// constants for the lidar control command interpreter
`ifndef LCCI_CONSTS_SVH
`define LCCI_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define LCCI_OFF_CMD     8'h00
`define LCCI_OFF_ARG0    8'h04
`define LCCI_OFF_ARG1    8'h08
`define LCCI_OFF_ARG2    8'h0c
`define LCCI_OFF_ARG3    8'h10
`define LCCI_OFF_REPLY   8'h14
`define LCCI_OFF_STATUS  8'h18
`define LCCI_OFF_PDSTAT  8'h1c
`define LCCI_OFF_WIN01   8'h20
`define LCCI_OFF_WIN23   8'h24

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define LCCI_CMD_EOL_BIT   8
`define LCCI_REPLY_EOL_BIT 24
`define LCCI_INF_CYCLES    16'hffff
`define LCCI_WIN_SPAN      17'h00400
`define LCCI_CAP_BLOCK_BIT 4
`define LCCI_BLOCK_OFF     32'h00000004
`define LCCI_NUM_MEM       32'h00000004
`define LCCI_NUM_PD        32'h00000004
`define LCCI_ERR_NOCAP     8'h01
`define LCCI_ERR_BADMEM    8'h02
// arbitrary neutral administrator password after reset
`define LCCI_ADMIN_PW_RST  32'h0000a5a5

`endif

// ==== lcci_pkg.sv ====
// types for the lidar control command interpreter
`default_nettype none
`include "lcci_consts.svh"

package lcci_pkg;

   // ----------------------------------------------------------------
   // command opcodes and reply codes
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      OP_LOGIN    = 8'h01,
      OP_HOSTS    = 8'h02,
      OP_LIMIT    = 8'h03,
      OP_FREE     = 8'h04,
      OP_STRSTART = 8'h05,
      OP_STRSTOP  = 8'h06,
      OP_SIGN     = 8'h07,
      OP_WINDOW   = 8'h08,
      OP_PDSTAT   = 8'h09,
      OP_PDTHERM  = 8'h0a,
      OP_PDBIAS   = 8'h0b,
      OP_BLOCK    = 8'h0c
   } lcci_op_e;

   typedef enum logic [7:0] {
      RP_NONE      = 8'h00,
      RP_EXEC      = 8'h01,
      RP_LIMITED   = 8'h02,
      RP_UNLIMITED = 8'h03,
      RP_NOT_ACC   = 8'h04,
      RP_NA        = 8'h05,
      RP_FAIL      = 8'h06,
      RP_UNKNOWN   = 8'h07,
      RP_DENIED    = 8'h08
   } lcci_reply_e;

   // ----------------------------------------------------------------
   // stream state machine and whole module state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ACCUM = 3'b010,
      ST_PUSH  = 3'b100
   } lcci_st_e;

   typedef struct packed {
      logic [31:0]       rdata;
      logic [3:0][31:0]  arg;
      lcci_reply_e       reply_code;
      logic [7:0]        reply_echo;
      logic [7:0]        reply_err;
      logic [31:0]       pd_stat;
      logic [31:0]       admin_pw;
      logic              secure;
      logic              logged;
      logic [31:0]       conn_pw;
      logic [3:0][31:0]  hosts;
      logic [3:0]        host_vld;
      logic [1:0]        host_wp;
      logic              client_ok;
      lcci_st_e          st;
      logic [15:0]       shots;
      logic [15:0]       shot_cnt;
      logic [15:0]       cycles;
      logic [3:0][31:0]  sum_s;
      logic [3:0][31:0]  sum_b;
      logic [30:0]       id_mag;
      logic              id_neg;
      logic              push_valid;
      logic [31:0]       push_id;
      logic [3:0][15:0]  push_sig;
      logic [3:0][15:0]  push_bg;
      logic [3:0][15:0]  win;
      logic [3:0][15:0]  pd_bias;
      logic [3:0]        pd_treg;
      logic [3:0]        trig_block;
   } lcci_state_s;

endpackage : lcci_pkg

`default_nettype wire

// ==== lcci_top.sv ====
// command interpreter: secure access, boresight stream, photodiode and trigger-mask commands
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lcci_consts.svh"

module lcci_top
   import lcci_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // client admission
   input  wire logic        new_client,
   input  wire logic [31:0] client_host,
   output logic             client_ok,
   output logic             secure_on,
   // per-shot boresight samples, four channels of 16 bits
   input  wire logic        shot_valid,
   input  wire logic [63:0] shot_sig,
   input  wire logic [63:0] shot_bg,
   // data push
   output logic             push_valid,
   output logic      [31:0] push_id,
   output logic      [63:0] push_sig,
   output logic      [63:0] push_bg,
   // photodiode units
   input  wire logic [3:0]  pd_present,
   input  wire logic [3:0]  pd_bias_under_local_control,
   input  wire logic [3:0]  pd_t_in_range,
   input  wire logic [3:0]  pd_t_local,
   output logic      [63:0] pd_bias,
   output logic      [3:0]  pd_treg_on,
   // acquisition recorder
   input  wire logic [7:0]  hardware_capability_word,
   output logic      [3:0]  trig_block
);

   // ----------------------------------------------------------------
   // state, decode and helpers
   // ----------------------------------------------------------------
   lcci_state_s q;
   lcci_state_s n;
   logic [3:0]  host_hit;
   logic        cmd_go;
   lcci_op_e    op;
   logic        served;
   logic        win_ok;
   logic        pd_ok;
   logic [1:0]  pd_dev;
   logic        blk_cap;

   // a line without its terminator is incomplete and not executed
   assign cmd_go  = wr && (addr == `LCCI_OFF_CMD) && wdata[`LCCI_CMD_EOL_BIT];
   assign op      = lcci_op_e'(wdata[7:0]);
   // in secure mode only an admitted client is served, and only login before the session opens
   assign served  = !q.secure || (q.client_ok && (q.logged || (op == OP_LOGIN)));
   assign pd_dev  = q.arg[0][1:0];
   assign pd_ok   = (q.arg[0] < `LCCI_NUM_PD) && pd_present[pd_dev];
   assign blk_cap = hardware_capability_word[`LCCI_CAP_BLOCK_BIT];

   // one ordered chain of window bounds
   function automatic logic win_chain(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] c, input logic [15:0] d);
      logic ok;
      ok = (a != 16'h0) && ({1'b0, a} < `LCCI_WIN_SPAN);
      ok = ok && (b > a) && ({1'b0, b} < ({1'b0, a} + `LCCI_WIN_SPAN));
      ok = ok && (c > b) && ({1'b0, c} < ({1'b0, b} + `LCCI_WIN_SPAN));
      ok = ok && (d > c) && ({1'b0, d} < ({1'b0, c} + `LCCI_WIN_SPAN));
      win_chain = ok;
   endfunction : win_chain

   // either pair order is legal
   assign win_ok = win_chain(q.arg[0][15:0], q.arg[1][15:0], q.arg[2][15:0], q.arg[3][15:0])
                || win_chain(q.arg[2][15:0], q.arg[3][15:0], q.arg[0][15:0], q.arg[1][15:0]);

   // allowed-host table lookup
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_host
         assign host_hit[gi] = q.host_vld[gi] && (q.hosts[gi] == client_host);
      end
   endgenerate

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic [30:0] mag;
      mag = q.id_mag + 31'h1;
      n = q;
      n.rdata = 32'h0;
      n.push_valid = 1'b0;

      // register writes and reads; read data stand one cycle only
      if (wr) begin
         case (addr)
            `LCCI_OFF_ARG0: n.arg[0] = wdata;
            `LCCI_OFF_ARG1: n.arg[1] = wdata;
            `LCCI_OFF_ARG2: n.arg[2] = wdata;
            `LCCI_OFF_ARG3: n.arg[3] = wdata;
            default: ;
         endcase
      end
      if (rd) begin
         case (addr)
            `LCCI_OFF_ARG0:   n.rdata = q.arg[0];
            `LCCI_OFF_ARG1:   n.rdata = q.arg[1];
            `LCCI_OFF_ARG2:   n.rdata = q.arg[2];
            `LCCI_OFF_ARG3:   n.rdata = q.arg[3];
            `LCCI_OFF_REPLY:  n.rdata = {7'h0, (q.reply_code != RP_NONE), q.reply_err,
                                         q.reply_echo, q.reply_code};
            `LCCI_OFF_STATUS: n.rdata = {25'h0, q.st, q.id_neg, q.client_ok, q.logged, q.secure};
            `LCCI_OFF_PDSTAT: n.rdata = q.pd_stat;
            `LCCI_OFF_WIN01:  n.rdata = {q.win[1], q.win[0]};
            `LCCI_OFF_WIN23:  n.rdata = {q.win[3], q.win[2]};
            default:          n.rdata = 32'h0;
         endcase
      end

      // a new connection starts logged out and is screened
      if (new_client) begin
         n.logged    = 1'b0;
         n.client_ok = !q.secure || (|host_hit);
      end

      // boresight averaging and push
      case (q.st)
         ST_IDLE: ;
         ST_ACCUM: begin
            if (shot_valid) begin
               for (int i = 0; i < 4; i++) begin
                  n.sum_s[i] = q.sum_s[i] + {16'h0, shot_sig[i*16 +: 16]};
                  n.sum_b[i] = q.sum_b[i] + {16'h0, shot_bg[i*16 +: 16]};
               end
               if (q.shot_cnt + 16'h1 == q.shots) begin
                  n.shot_cnt = 16'h0;
                  n.st       = ST_PUSH;
               end else begin
                  n.shot_cnt = q.shot_cnt + 16'h1;
               end
            end
         end
         ST_PUSH: begin
            // the divide is wide but only used once per data set
            for (int i = 0; i < 4; i++) begin
               n.push_sig[i] = 16'(q.sum_s[i] / {16'h0, q.shots});
               n.push_bg[i]  = 16'(q.sum_b[i] / {16'h0, q.shots});
               n.sum_s[i]    = 32'h0;
               n.sum_b[i]    = 32'h0;
            end
            n.id_mag     = mag;
            n.push_id    = q.id_neg ? (~{1'b0, mag} + 32'h1) : {1'b0, mag};
            n.push_valid = 1'b1;
            if (q.cycles == `LCCI_INF_CYCLES) begin
               n.st = ST_ACCUM;
            end else if (q.cycles == 16'h1) begin
               n.st = ST_IDLE;
            end else begin
               n.cycles = q.cycles - 16'h1;
               n.st     = ST_ACCUM;
            end
         end
         default: n.st = ST_IDLE;
      endcase

      // command execution; stop here overrides the stream above
      if (cmd_go) begin
         n.reply_echo = wdata[7:0];
         n.reply_err  = 8'h0;
         if (!served) begin
            n.reply_code = RP_DENIED;
         end else begin
            case (op)
               OP_LOGIN: begin
                  if (!q.secure || (q.arg[0] == q.conn_pw)) begin
                     n.logged     = q.secure;
                     n.reply_code = RP_EXEC;
                  end else begin
                     n.reply_code = RP_NOT_ACC;
                  end
               end
               OP_HOSTS: begin
                  n.hosts[q.host_wp]    = q.arg[0];
                  n.host_vld[q.host_wp] = 1'b1;
                  n.host_wp             = q.host_wp + 2'h1;
                  n.reply_code          = RP_EXEC;
               end
               OP_LIMIT: begin
                  if ((q.arg[0] == q.admin_pw) && (q.arg[1] != 32'h0)) begin
                     n.secure     = 1'b1;
                     n.logged     = 1'b0;
                     n.conn_pw    = q.arg[1];
                     n.reply_code = RP_LIMITED;
                  end else begin
                     n.reply_code = RP_NOT_ACC;
                  end
               end
               OP_FREE: begin
                  // reaching here while secure already implies a logged-in session
                  if (q.arg[0] == q.admin_pw) begin
                     n.secure     = 1'b0;
                     n.logged     = 1'b0;
                     n.reply_code = RP_UNLIMITED;
                  end else begin
                     n.reply_code = RP_NOT_ACC;
                  end
               end
               OP_STRSTART: begin
                  n.shots      = (q.arg[0][15:0] == 16'h0) ? 16'h1 : q.arg[0][15:0];
                  n.cycles     = (q.arg[1][15:0] == 16'h0) ? 16'h1 : q.arg[1][15:0];
                  n.shot_cnt   = 16'h0;
                  n.sum_s      = '0;
                  n.sum_b      = '0;
                  n.st         = ST_ACCUM;
                  n.reply_code = RP_EXEC;
               end
               OP_STRSTOP: begin
                  n.st         = ST_IDLE;
                  n.reply_code = RP_EXEC;
               end
               OP_SIGN: begin
                  n.id_neg     = !q.id_neg;
                  n.reply_code = RP_EXEC;
               end
               OP_WINDOW: begin
                  if (win_ok) begin
                     for (int i = 0; i < 4; i++) begin
                        n.win[i] = q.arg[i][15:0];
                     end
                     n.reply_code = RP_EXEC;
                  end else begin
                     n.reply_code = RP_FAIL;
                  end
               end
               OP_PDSTAT: begin
                  if (pd_ok) begin
                     n.pd_stat    = {12'h0, pd_t_local[pd_dev], pd_t_in_range[pd_dev], q.pd_treg[pd_dev],
                                     pd_bias_under_local_control[pd_dev], q.pd_bias[pd_dev]};
                     n.reply_code = RP_EXEC;
                  end else begin
                     n.reply_code = RP_NA;
                  end
               end
               OP_PDTHERM: begin
                  if (pd_ok) begin
                     n.pd_treg[pd_dev] = q.arg[1][0];
                     n.reply_code      = RP_EXEC;
                  end else begin
                     n.reply_code = RP_NA;
                  end
               end
               OP_PDBIAS: begin
                  if (pd_ok) begin
                     n.pd_bias[pd_dev] = q.arg[1][15:0];
                     n.reply_code      = RP_EXEC;
                  end else begin
                     n.reply_code = RP_NA;
                  end
               end
               OP_BLOCK: begin
                  if (!blk_cap) begin
                     n.reply_code = RP_FAIL;
                     n.reply_err  = `LCCI_ERR_NOCAP;
                  end else if (q.arg[0] == `LCCI_BLOCK_OFF) begin
                     n.trig_block = 4'h0;
                     n.reply_code = RP_EXEC;
                  end else if (q.arg[0] < `LCCI_NUM_MEM) begin
                     n.trig_block[q.arg[0][1:0]] = 1'b1;
                     n.reply_code = RP_EXEC;
                  end else begin
                     n.reply_code = RP_FAIL;
                     n.reply_err  = `LCCI_ERR_BADMEM;
                  end
               end
               default: n.reply_code = RP_UNKNOWN;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q          <= '0;
         q.st       <= ST_IDLE;
         q.admin_pw <= `LCCI_ADMIN_PW_RST;
      end else begin
         q <= n;
      end
   end

   // outputs straight from the state register
   assign rdata      = q.rdata;
   assign client_ok  = q.client_ok;
   assign secure_on  = q.secure;
   assign push_valid = q.push_valid;
   assign push_id    = q.push_id;
   assign push_sig   = q.push_sig;
   assign push_bg    = q.push_bg;
   assign pd_bias    = q.pd_bias;
   assign pd_treg_on = q.pd_treg;
   assign trig_block = q.trig_block;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_limit_on;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && op == OP_LIMIT && q.arg[0] == q.admin_pw && q.arg[1] != 32'h0)
         |=> (q.secure && q.reply_code == RP_LIMITED && q.conn_pw == $past(q.arg[1]));
   endproperty
   a_limit_on: assert property (p_limit_on) else $error("limit did not enable secure mode");

   property p_limit_bad;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && op == OP_LIMIT && q.arg[0] != q.admin_pw)
         |=> (q.reply_code == RP_NOT_ACC && q.secure == $past(q.secure));
   endproperty
   a_limit_bad: assert property (p_limit_bad) else $error("bad password not refused");

   property p_host_gate;
      @(posedge clk) disable iff (rst)
      (new_client && q.secure && host_hit == 4'h0) |=> !client_ok;
   endproperty
   a_host_gate: assert property (p_host_gate) else $error("unlisted host admitted");

   property p_free_locked;
      @(posedge clk) disable iff (rst)
      (q.secure && !q.logged && cmd_go && op == OP_FREE) |=> (q.secure && q.reply_code == RP_DENIED);
   endproperty
   a_free_locked: assert property (p_free_locked) else $error("secure mode left without login");

   property p_id_step;
      @(posedge clk) disable iff (rst)
      (q.st == ST_PUSH) |=> (push_valid && q.id_mag == $past(q.id_mag) + 31'h1);
   endproperty
   a_id_step: assert property (p_id_step) else $error("identifier did not step by one");

   property p_sign_toggle;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && op == OP_SIGN) |=> (q.id_neg != $past(q.id_neg) && q.reply_code == RP_EXEC);
   endproperty
   a_sign_toggle: assert property (p_sign_toggle) else $error("sign not toggled");

   property p_win_keep;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && op == OP_WINDOW && !win_ok) |=> (q.win == $past(q.win) && q.reply_code == RP_FAIL);
   endproperty
   a_win_keep: assert property (p_win_keep) else $error("illegal window accepted");

   property p_pd_na;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && (op == OP_PDSTAT || op == OP_PDTHERM || op == OP_PDBIAS) && !pd_ok)
         |=> (q.reply_code == RP_NA && pd_bias == $past(pd_bias));
   endproperty
   a_pd_na: assert property (p_pd_na) else $error("missing unit not reported");

   property p_block_cap;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && op == OP_BLOCK && !blk_cap)
         |=> (trig_block == $past(trig_block) && q.reply_err == `LCCI_ERR_NOCAP);
   endproperty
   a_block_cap: assert property (p_block_cap) else $error("mask without capability");

   property p_block_off;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && op == OP_BLOCK && blk_cap && q.arg[0] == `LCCI_BLOCK_OFF) |=> (trig_block == 4'h0);
   endproperty
   a_block_off: assert property (p_block_off) else $error("mask off did not clear");

   property p_unknown;
      @(posedge clk) disable iff (rst)
      (cmd_go && served && wdata[7:0] > 8'h0c)
         |=> (q.reply_code == RP_UNKNOWN && q.reply_echo == $past(wdata[7:0]));
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown command not echoed");

endmodule : lcci_top

`default_nettype wire

// ==== lcci_shot_src.sv ====
// partner model: boresight detector feeding per-shot samples
`timescale 1ns/1ps
`default_nettype none

module lcci_shot_src (
   // clock and request
   input  wire logic        clk,
   input  wire logic        fire,
   input  wire logic [15:0] s,
   input  wire logic [15:0] b,
   // shot samples, same value on all four lanes
   output logic             shot_valid,
   output logic      [63:0] shot_sig,
   output logic      [63:0] shot_bg
);
   initial begin
      shot_valid = 1'b0;
      shot_sig   = 64'h0;
      shot_bg    = 64'h0;
   end
   // lines toggle between shots so a stale sample never looks valid
   always @(posedge clk) begin
      shot_valid <= fire;
      shot_sig   <= fire ? {4{s}} : ~shot_sig;
      shot_bg    <= fire ? {4{b}} : ~shot_bg;
   end
endmodule : lcci_shot_src

`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "lcci_consts.svh"

module testbench;
   import lcci_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, new_client = 1'b0, fire = 1'b0;
   logic [7:0]  addr = 8'h0, cap = 8'h0;
   logic [31:0] wdata = 32'h0, host = 32'h0, r, rdata, push_id;
   logic [15:0] sv = 16'h0, bv = 16'h0;
   logic        client_ok, secure_on, push_valid, shot_valid;
   logic [63:0] shot_sig, shot_bg, push_sig, push_bg, pd_bias;
   logic [3:0]  pd_treg_on, trig_block;
   int          n_fail = 0, checks_done = 0;

   always #12.5 clk = ~clk;

   lcci_shot_src i_src (.clk(clk), .fire(fire), .s(sv), .b(bv), .shot_valid(shot_valid),
      .shot_sig(shot_sig), .shot_bg(shot_bg));
   lcci_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .new_client(new_client), .client_host(host), .client_ok(client_ok), .secure_on(secure_on),
      .shot_valid(shot_valid), .shot_sig(shot_sig), .shot_bg(shot_bg), .push_valid(push_valid),
      .push_id(push_id), .push_sig(push_sig), .push_bg(push_bg), .pd_present(4'h7),
      .pd_bias_under_local_control(4'h2), .pd_t_in_range(4'h2), .pd_t_local(4'h0), .pd_bias(pd_bias),
      .pd_treg_on(pd_treg_on), .hardware_capability_word(cap), .trig_block(trig_block));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   // arguments first, then the line-ended command word, then the reply
   task automatic cmd(input logic [7:0] op, input logic [31:0] a0, a1, a2, a3, output logic [31:0] rep);
      wr_reg(`LCCI_OFF_ARG0, a0);
      wr_reg(`LCCI_OFF_ARG1, a1);
      wr_reg(`LCCI_OFF_ARG2, a2);
      wr_reg(`LCCI_OFF_ARG3, a3);
      wr_reg(`LCCI_OFF_CMD, {23'h0, 1'b1, op});
      rd_reg(`LCCI_OFF_REPLY, rep);
   endtask : cmd

   function automatic logic [31:0] rp(input logic [7:0] op, input logic [7:0] code, input logic [7:0] err);
      return {7'h0, 1'b1, err, op, code};
   endfunction : rp

   task automatic pulse_client(input logic [31:0] h);
      @(posedge clk);
      new_client <= 1'b1;
      host       <= h;
      @(posedge clk);
      new_client <= 1'b0;
      @(posedge clk);
   endtask : pulse_client

   task automatic shoot(input logic [15:0] s, input logic [15:0] b);
      @(posedge clk);
      fire <= 1'b1;
      sv   <= s;
      bv   <= b;
      @(posedge clk);
      fire <= 1'b0;
   endtask : shoot

   // bounded wait for the one-cycle push pulse, then judge the data set
   task automatic expect_push(input logic [31:0] id, input logic [15:0] s, input logic [15:0] b);
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         #1;
         if (push_valid === 1'b1) break;
      end
      check(push_valid, 1'b1);
      check(push_id, id);
      check(push_sig, {4{s}});
      check(push_bg, {4{b}});
   endtask : expect_push

   task automatic t_secure();
      cmd(OP_LIMIT, 32'h1, 32'h55, 0, 0, r);
      check(r, rp(OP_LIMIT, RP_NOT_ACC, 0));
      cmd(OP_HOSTS, 32'h0a, 0, 0, 0, r);
      check(r, rp(OP_HOSTS, RP_EXEC, 0));
      cmd(OP_LIMIT, `LCCI_ADMIN_PW_RST, 32'h55, 0, 0, r);
      check({r, 31'h0, secure_on}, {rp(OP_LIMIT, RP_LIMITED, 0), 32'h1});
      pulse_client(32'h0b);
      check(client_ok, 1'b0);
      cmd(OP_LOGIN, 32'h55, 0, 0, 0, r);
      check(r, rp(OP_LOGIN, RP_DENIED, 0));
      pulse_client(32'h0a);
      check(client_ok, 1'b1);
      cmd(OP_FREE, `LCCI_ADMIN_PW_RST, 0, 0, 0, r);
      check({r, 31'h0, secure_on}, {rp(OP_FREE, RP_DENIED, 0), 32'h1});
      cmd(OP_LOGIN, 32'h55, 0, 0, 0, r);
      check(r, rp(OP_LOGIN, RP_EXEC, 0));
      cmd(OP_FREE, `LCCI_ADMIN_PW_RST, 0, 0, 0, r);
      check({r, 31'h0, secure_on}, {rp(OP_FREE, RP_UNLIMITED, 0), 32'h0});
   endtask : t_secure

   task automatic t_stream();
      cmd(OP_STRSTART, 32'h2, 32'h2, 0, 0, r);
      check(r, rp(OP_STRSTART, RP_EXEC, 0));
      shoot(16'd10, 16'd4);
      shoot(16'd20, 16'd6);
      expect_push(32'h1, 16'd15, 16'd5);
      cmd(OP_SIGN, 0, 0, 0, 0, r);
      check(r, rp(OP_SIGN, RP_EXEC, 0));
      shoot(16'd7, 16'd1);
      shoot(16'd8, 16'd2);
      expect_push(32'hffff_fffe, 16'd7, 16'd1);
      rd_reg(`LCCI_OFF_STATUS, r);
      check(r[6:4], 3'b001);
      // endless run: one shot per data set until stopped
      cmd(OP_STRSTART, 32'h1, 32'hffff_ffff, 0, 0, r);
      check(r, rp(OP_STRSTART, RP_EXEC, 0));
      shoot(16'd9, 16'd3);
      expect_push(32'hffff_fffd, 16'd9, 16'd3);
      shoot(16'd5, 16'd2);
      expect_push(32'hffff_fffc, 16'd5, 16'd2);
      cmd(OP_STRSTOP, 0, 0, 0, 0, r);
      check(r, rp(OP_STRSTOP, RP_EXEC, 0));
      // a command word without its line end must leave the sign alone
      wr_reg(`LCCI_OFF_CMD, {24'h0, OP_SIGN});
      rd_reg(`LCCI_OFF_STATUS, r);
      check(r[6:3], 4'b0011);
   endtask : t_stream

   task automatic t_window();
      cmd(OP_WINDOW, 400, 850, 1200, 1600, r);
      check(r, rp(OP_WINDOW, RP_EXEC, 0));
      cmd(OP_WINDOW, 1200, 1600, 400, 850, r);
      check(r, rp(OP_WINDOW, RP_EXEC, 0));
      cmd(OP_WINDOW, 100, 1124, 1200, 1300, r);
      check(r, rp(OP_WINDOW, RP_FAIL, 0));
      rd_reg(`LCCI_OFF_WIN01, r);
      check(r, {16'd1600, 16'd1200});
   endtask : t_window

   task automatic t_pd_block();
      cmd(OP_PDBIAS, 1, 300, 0, 0, r);
      check({r, pd_bias[31:16]}, {rp(OP_PDBIAS, RP_EXEC, 0), 16'd300});
      cmd(OP_PDTHERM, 1, 1, 0, 0, r);
      check({r, 28'h0, pd_treg_on}, {rp(OP_PDTHERM, RP_EXEC, 0), 32'h2});
      cmd(OP_PDSTAT, 1, 0, 0, 0, r);
      rd_reg(`LCCI_OFF_PDSTAT, r);
      check(r, 32'h0007_012c);
      cmd(OP_PDSTAT, 0, 0, 0, 0, r);
      check(r, rp(OP_PDSTAT, RP_EXEC, 0));
      cmd(OP_PDBIAS, 4, 5, 0, 0, r);
      check(r, rp(OP_PDBIAS, RP_NA, 0));
      cmd(OP_PDTHERM, 3, 1, 0, 0, r);
      check(r, rp(OP_PDTHERM, RP_NA, 0));
      cmd(OP_BLOCK, 0, 0, 0, 0, r);
      check(r, rp(OP_BLOCK, RP_FAIL, `LCCI_ERR_NOCAP));
      @(posedge clk);
      cap <= 8'h10;
      cmd(OP_BLOCK, 1, 0, 0, 0, r);
      cmd(OP_BLOCK, 2, 0, 0, 0, r);
      check({r, 28'h0, trig_block}, {rp(OP_BLOCK, RP_EXEC, 0), 32'h6});
      cmd(OP_BLOCK, 5, 0, 0, 0, r);
      check(r, rp(OP_BLOCK, RP_FAIL, `LCCI_ERR_BADMEM));
      cmd(OP_BLOCK, `LCCI_BLOCK_OFF, 0, 0, 0, r);
      check({r, 28'h0, trig_block}, {rp(OP_BLOCK, RP_EXEC, 0), 32'h0});
      cmd(8'h0d, 0, 0, 0, 0, r);
      check(r, rp(8'h0d, RP_UNKNOWN, 0));
   endtask : t_pd_block

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report

   // main sequence, then a watchdog well beyond the expected run
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd_reg(`LCCI_OFF_STATUS, r);
      check(r, 32'h10);
      t_secure();
      t_stream();
      t_window();
      t_pd_block();
      final_report();
   end
   initial begin
      #2000000;
      n_fail++;
      final_report();
   end
endmodule : testbench

`default_nettype wire
